/* common/gas_alarm_pkg.sv */
// Purpose: shared constants, types and helpers for the gas alarm evaluator
// Assumes: readings and set-points are unsigned counts of the smallest step
// Notes: full scale and default set-points are plain defaults
package gas_alarm_pkg;
  localparam int RD_W = 10;
  localparam int FULL_SCALE = 1000;
  localparam logic [RD_W-1:0] SP_MIN = 10'h001;
  localparam logic [RD_W-1:0] SP_MAX = 10'((FULL_SCALE * 70) / 100);
  localparam logic [RD_W-1:0] SP1_RST = 10'h0C8;
  localparam logic [RD_W-1:0] SP2_RST = 10'h190;
  localparam logic DIR_RISE = 1'b1;
  localparam logic [RD_W-1:0] MARGIN_DIV = 10'h00A;
  // one second tick from the 8 ns clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int SECOND_NS = 1000000000;
  localparam int TICK_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 27;
  localparam int LOCK_TIME_S = 60;
  localparam logic [5:0] LOCK_SECS = 6'(LOCK_TIME_S);
  localparam logic [3:0] FC_NONE = 4'h0;
  localparam logic [3:0] FC_ADAPTER = 4'h1;
  localparam logic [3:0] FC_INTERFACE = 4'h4;
  localparam logic [3:0] FC_ZERO = 4'h5;
  localparam logic [3:0] FC_CAL = 4'h6;

  typedef enum logic [2:0] {
    SCR_NORMAL,
    SCR_SP1,
    SCR_DIR1,
    SCR_SP2,
    SCR_DIR2,
    SCR_CAL_READY,
    SCR_CAL_RUN
  } screen_e;

  function automatic logic [RD_W-1:0] ten_pct(input logic [RD_W-1:0] v);
    ten_pct = v / MARGIN_DIV;
  endfunction : ten_pct

  function automatic logic [RD_W-1:0] step_sp(input logic [RD_W-1:0] v,
                                               input logic up,
                                               input logic dn);
    if (up && v < SP_MAX) begin
      step_sp = v + 10'h001;
    end else if (!up && dn && v > SP_MIN) begin
      step_sp = v - 10'h001;
    end else begin
      step_sp = v;
    end
  endfunction : step_sp
endpackage : gas_alarm_pkg

/* hw/sec_tick.sv */
// Purpose: one-cycle tick once per second of clock
// Assumes: clear restarts the second from zero
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/10ps
`default_nettype none
module sec_tick
  import gas_alarm_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic clear_in,
  output logic tick_out
);
  logic [TICK_W-1:0] cnt_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      if (clear_in) begin
        cnt_r <= '0;
        tick_out <= 1'b0;
      end else if (cnt_r == TICK_W'(CYCLES - 1)) begin
        cnt_r <= '0;
        tick_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + TICK_W'(1);
        tick_out <= 1'b0;
      end
    end
  end
endmodule : sec_tick
`default_nettype wire

/* hw/alarm_channel.sv */
// Purpose: one alarm level with direction, hysteresis and latching
// Assumes: reading_in is held while valid_in is high
// Notes: trip beats manual reset when both occur together
`timescale 1ns/10ps
`default_nettype none
module alarm_channel
  import gas_alarm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [RD_W-1:0] reading_in,
  input wire logic valid_in,
  input wire logic [RD_W-1:0] setpoint_in,
  input wire logic rise_in,
  input wire logic latch_in,
  input wire logic reset_in,
  input wire logic lock_in,
  output logic alarm_out
);
  logic [RD_W-1:0] rel_lo_r;
  logic [RD_W-1:0] rel_hi_r;
  logic trip;
  logic release_ok;

  // release thresholds registered to keep the divide off the compare path
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rel_lo_r <= '0;
      rel_hi_r <= '1;
    end else if (ce_in) begin
      rel_lo_r <= setpoint_in - ten_pct(setpoint_in); // see (R20)
      rel_hi_r <= setpoint_in + ten_pct(setpoint_in); // see (R20)
    end
  end

  // see (R05)
  assign trip = rise_in ? (reading_in >= setpoint_in) : (reading_in <= setpoint_in);
  assign release_ok = rise_in ? (reading_in < rel_lo_r) : (reading_in > rel_hi_r);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_out <= 1'b0;
    end else if (ce_in) begin
      if (valid_in && trip && !lock_in) begin
        alarm_out <= 1'b1; // see (R07) see (R08) see (R19)
      end else if (latch_in ? reset_in : (valid_in && release_ok)) begin
        alarm_out <= 1'b0; // see (R09) see (R19)
      end
    end
  end

  property p_trip_rise;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && valid_in && rise_in && !lock_in && reading_in >= setpoint_in |=> alarm_out;
  endproperty
  a_trip_rise: assert property (p_trip_rise) else $error("rising trip missed"); // see (R07)

  property p_trip_fall;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && valid_in && !rise_in && !lock_in && reading_in <= setpoint_in |=> alarm_out;
  endproperty
  a_trip_fall: assert property (p_trip_fall) else $error("falling trip missed"); // see (R19)

  property p_latch_hold;
    @(posedge clk_in) disable iff (rst_in)
    alarm_out && latch_in && !reset_in |=> alarm_out;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped"); // see (R09)

  property p_auto_hold;
    @(posedge clk_in) disable iff (rst_in)
    alarm_out && !latch_in && rise_in && reading_in >= rel_lo_r |=> alarm_out;
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("released inside margin"); // see (R09)

  property p_margin;
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> rel_lo_r == $past(setpoint_in) - ($past(setpoint_in) / MARGIN_DIV);
  endproperty
  a_margin: assert property (p_margin) else $error("release margin wrong"); // see (R20)
endmodule : alarm_channel
`default_nettype wire

/* hw/gas_alarm_evaluator.sv */
// Purpose: two-level gas alarm evaluator with settings menu and calibration
// Assumes: keys and strobes are one-cycle pulses synchronous to clk_in
// Notes: times count one-second ticks; ce_in low freezes every register
`timescale 1ns/10ps
`default_nettype none
// How it works
// (R01) two alarms, own set-point and direction
// (R02) alarms evaluated whether relays fitted or not
// (R03) set-points clamped from one step to 70%
// (R04) user keeps first set-point below second
// (R05) each alarm rises or falls, selectable
// (R06) factory reset: both alarms rising
// (R07) at or above first set-point: amber
// (R08) at or above second set-point: red
// (R09) auto release 10% below; latching needs reset
// (R10) relays follow their alarms when fitted
// (R11) no alarm until one minute after menu
// (R12) add raises, sub lowers set-point
// (R13) add picks rising, sub picks falling
// (R14) menu saves, steps through four screens
// (R15) menu at start screen runs timed calibration
// (R16) running calibration cannot be aborted
// (R17) distinct codes for four faults
// (R18) any fault drives fault output
// (R19) falling alarms: at or below, release 10% above
// (R20) release margin from set-point, registered compare
module gas_alarm_evaluator
  import gas_alarm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [RD_W-1:0] reading_in,
  input wire logic reading_valid_in,
  input wire logic key_menu_in,
  input wire logic key_add_in,
  input wire logic key_sub_in,
  input wire logic cal_screen_in,
  input wire logic [9:0] cal_secs_in,
  input wire logic latch1_in,
  input wire logic latch2_in,
  input wire logic manual_reset_in,
  input wire logic relay_fitted_in,
  input wire logic adapter_link_lost_in,
  input wire logic interface_link_lost_in,
  input wire logic zero_failed_in,
  input wire logic calibration_failed_in,
  output logic amber_out,
  output logic red_out,
  output logic relay1_out,
  output logic relay2_out,
  output logic lockout_out,
  output logic [2:0] screen_out,
  output logic [RD_W-1:0] edit_sp_out,
  output logic edit_dir_out,
  output logic [9:0] cal_remaining_out,
  output logic adapter_link_lost_fault_out,
  output logic interface_link_lost_fault_out,
  output logic zero_failed_fault_out,
  output logic calibration_failed_fault_out,
  output logic [3:0] fault_code_out,
  output logic fault_out
);
  screen_e screen_r;
  screen_e screen_nxt;
  logic [RD_W-1:0] sp1_r;
  logic [RD_W-1:0] sp2_r;
  logic dir1_r;
  logic dir2_r;
  logic [RD_W-1:0] edit_sp_r;
  logic edit_dir_r;
  logic [9:0] cal_cnt_r;
  logic [5:0] lock_cnt_r;
  logic tick;
  logic tick_clear;
  logic alarm1;
  logic alarm2;
  logic menu_go;

  assign menu_go = key_menu_in;
  // keep the second counter cleared to zero inside the menu so the lockout is full length
  assign tick_clear = (screen_r != SCR_NORMAL) && (screen_r != SCR_CAL_RUN);

  sec_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .clear_in(tick_clear),
    .tick_out(tick)
  );

  always_comb begin
    screen_nxt = screen_r;
    case (screen_r)
      SCR_NORMAL: begin
        if (menu_go) begin
          screen_nxt = SCR_SP1;
        end else if (cal_screen_in) begin
          screen_nxt = SCR_CAL_READY;
        end
      end
      SCR_CAL_READY: begin
        if (menu_go) begin
          screen_nxt = SCR_CAL_RUN; // see (R15)
        end
      end
      SCR_CAL_RUN: begin
        // keys are not looked at here at all
        if (tick && cal_cnt_r <= 10'h001) begin
          screen_nxt = SCR_NORMAL; // see (R16)
        end
      end
      SCR_SP1: begin
        if (menu_go) begin
          screen_nxt = SCR_DIR1; // see (R14)
        end
      end
      SCR_DIR1: begin
        if (menu_go) begin
          screen_nxt = SCR_SP2; // see (R14)
        end
      end
      SCR_SP2: begin
        if (menu_go) begin
          screen_nxt = SCR_DIR2; // see (R14)
        end
      end
      SCR_DIR2: begin
        if (menu_go) begin
          screen_nxt = SCR_NORMAL; // see (R14)
        end
      end
      default: begin
        screen_nxt = SCR_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      screen_r <= SCR_NORMAL;
    end else if (ce_in) begin
      screen_r <= screen_nxt;
    end
  end

  assign screen_out = screen_r;

  // stored settings, written only by the menu key
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sp1_r <= SP1_RST;
      sp2_r <= SP2_RST;
      dir1_r <= DIR_RISE; // see (R06)
      dir2_r <= DIR_RISE; // see (R06)
    end else if (ce_in && menu_go) begin
      case (screen_r)
        SCR_SP1: sp1_r <= edit_sp_r; // see (R01) see (R14)
        SCR_DIR1: dir1_r <= edit_dir_r;
        SCR_SP2: sp2_r <= edit_sp_r;
        SCR_DIR2: dir2_r <= edit_dir_r;
        default: begin
        end
      endcase
    end
  end

  // working copy shown on screen; first set-point above second is not refused
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      edit_sp_r <= SP1_RST;
      edit_dir_r <= DIR_RISE;
    end else if (ce_in) begin
      if (menu_go) begin
        case (screen_r)
          SCR_NORMAL: edit_sp_r <= sp1_r;
          SCR_SP1: edit_dir_r <= dir1_r;
          SCR_DIR1: edit_sp_r <= sp2_r;
          SCR_SP2: edit_dir_r <= dir2_r;
          default: begin
          end
        endcase
      end else if (screen_r == SCR_SP1 || screen_r == SCR_SP2) begin
        edit_sp_r <= step_sp(edit_sp_r, key_add_in, key_sub_in); // see (R12) see (R03)
      end else if (screen_r == SCR_DIR1 || screen_r == SCR_DIR2) begin
        if (key_add_in) begin
          edit_dir_r <= 1'b1; // see (R13)
        end else if (key_sub_in) begin
          edit_dir_r <= 1'b0; // see (R13)
        end
      end
    end
  end

  assign edit_sp_out = edit_sp_r;
  assign edit_dir_out = edit_dir_r;

  // countdown length comes from the gas type
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cal_cnt_r <= '0;
    end else if (ce_in) begin
      if (screen_r == SCR_CAL_READY && menu_go) begin
        cal_cnt_r <= cal_secs_in; // see (R15)
      end else if (screen_r == SCR_CAL_RUN && tick && cal_cnt_r != 10'h000) begin
        cal_cnt_r <= cal_cnt_r - 10'h001;
      end
    end
  end

  assign cal_remaining_out = cal_cnt_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_cnt_r <= '0;
      lockout_out <= 1'b0;
    end else if (ce_in) begin
      if (screen_r != SCR_NORMAL) begin
        lock_cnt_r <= LOCK_SECS; // see (R11)
      end else if (tick && lock_cnt_r != 6'h00) begin
        lock_cnt_r <= lock_cnt_r - 6'h01;
      end
      lockout_out <= (screen_nxt != SCR_NORMAL) || (screen_r != SCR_NORMAL)
                     || (lock_cnt_r != 6'h00); // see (R11)
    end
  end

  alarm_channel u_alarm1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .reading_in(reading_in),
    .valid_in(reading_valid_in),
    .setpoint_in(sp1_r),
    .rise_in(dir1_r),
    .latch_in(latch1_in),
    .reset_in(manual_reset_in),
    .lock_in(lockout_out),
    .alarm_out(alarm1)
  );

  alarm_channel u_alarm2 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .reading_in(reading_in),
    .valid_in(reading_valid_in),
    .setpoint_in(sp2_r),
    .rise_in(dir2_r),
    .latch_in(latch2_in),
    .reset_in(manual_reset_in),
    .lock_in(lockout_out),
    .alarm_out(alarm2)
  );

  // indicators never depend on the relay option
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      amber_out <= 1'b0;
      red_out <= 1'b0;
      relay1_out <= 1'b0;
      relay2_out <= 1'b0;
    end else if (ce_in) begin
      amber_out <= alarm1; // see (R02) see (R07)
      red_out <= alarm2; // see (R02) see (R08)
      relay1_out <= alarm1 && relay_fitted_in; // see (R10)
      relay2_out <= alarm2 && relay_fitted_in; // see (R10)
    end
  end

  // lowest code wins when several faults stand at once
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      adapter_link_lost_fault_out <= 1'b0;
      interface_link_lost_fault_out <= 1'b0;
      zero_failed_fault_out <= 1'b0;
      calibration_failed_fault_out <= 1'b0;
      fault_code_out <= FC_NONE;
      fault_out <= 1'b0;
    end else if (ce_in) begin
      adapter_link_lost_fault_out <= adapter_link_lost_in;
      interface_link_lost_fault_out <= interface_link_lost_in;
      zero_failed_fault_out <= zero_failed_in;
      calibration_failed_fault_out <= calibration_failed_in;
      if (adapter_link_lost_in) begin
        fault_code_out <= FC_ADAPTER; // see (R17)
      end else if (interface_link_lost_in) begin
        fault_code_out <= FC_INTERFACE; // see (R17)
      end else if (zero_failed_in) begin
        fault_code_out <= FC_ZERO; // see (R17)
      end else if (calibration_failed_in) begin
        fault_code_out <= FC_CAL; // see (R17)
      end else begin
        fault_code_out <= FC_NONE;
      end
      fault_out <= adapter_link_lost_in || interface_link_lost_in
                   || zero_failed_in || calibration_failed_in; // see (R18)
    end
  end

  property p_sp_range;
    @(posedge clk_in) disable iff (rst_in)
    screen_r == SCR_SP1 |-> edit_sp_r <= SP_MAX || edit_sp_r == sp1_r;
  endproperty
  a_sp_range: assert property (p_sp_range) else $error("set-point above limit"); // see (R03)

  property p_relay;
    @(posedge clk_in) disable iff (rst_in)
    (relay1_out |-> amber_out) and (relay2_out |-> red_out);
  endproperty
  a_relay: assert property (p_relay) else $error("relay without alarm"); // see (R10)

  property p_lock;
    @(posedge clk_in) disable iff (rst_in)
    lockout_out && !alarm1 |=> !alarm1;
  endproperty
  a_lock: assert property (p_lock) else $error("alarm set during lockout"); // see (R11)

  property p_add;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && screen_r == SCR_SP2 && !menu_go && key_add_in && edit_sp_r < SP_MAX
    |=> edit_sp_r == $past(edit_sp_r) + 10'h001;
  endproperty
  a_add: assert property (p_add) else $error("add did not raise set-point"); // see (R12)

  property p_dir;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && screen_r == SCR_DIR1 && !menu_go && !key_add_in && key_sub_in
    |=> !edit_dir_r;
  endproperty
  a_dir: assert property (p_dir) else $error("sub did not pick falling"); // see (R13)

  property p_order;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && screen_r == SCR_DIR1 && menu_go |=> screen_r == SCR_SP2 && dir1_r == $past(edit_dir_r);
  endproperty
  a_order: assert property (p_order) else $error("menu step wrong"); // see (R14)

  property p_cal_hold;
    @(posedge clk_in) disable iff (rst_in)
    screen_r == SCR_CAL_RUN && cal_cnt_r > 10'h001 |=> screen_r == SCR_CAL_RUN;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration aborted"); // see (R16)

  property p_fault;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && zero_failed_in && !adapter_link_lost_in && !interface_link_lost_in
    |=> fault_out && fault_code_out == FC_ZERO;
  endproperty
  a_fault: assert property (p_fault) else $error("zero fault not reported"); // see (R17) see (R18)

  c_amber: cover property (@(posedge clk_in) disable iff (rst_in) $rose(amber_out));
  c_red: cover property (@(posedge clk_in) disable iff (rst_in) $rose(red_out));
  c_cal_done: cover property (@(posedge clk_in) disable iff (rst_in)
    screen_r == SCR_CAL_RUN ##1 screen_r == SCR_NORMAL);
  c_menu_out: cover property (@(posedge clk_in) disable iff (rst_in)
    screen_r == SCR_DIR2 ##1 screen_r == SCR_NORMAL);
endmodule : gas_alarm_evaluator
`default_nettype wire

/* testbench/sensor_board_model.sv */
// Purpose: sensor board model that hands readings to the evaluator
// Assumes: one reading per send pulse, valid for one cycle
// Notes: between readings the data lines toggle each cycle between the last value and its inverse
`timescale 1ns/10ps
`default_nettype none
module sensor_board_model
  import gas_alarm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic send_in,
  input wire logic [RD_W-1:0] value_in,
  output logic [RD_W-1:0] reading_out,
  output logic valid_out
);
  // stale data toggles so a reading taken without valid cannot match by luck
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reading_out <= '0;
      valid_out <= 1'h0;
    end else if (send_in) begin
      reading_out <= value_in;
      valid_out <= 1'h1;
    end else begin
      reading_out <= ~reading_out;
      valid_out <= 1'h0;
    end
  end
endmodule : sensor_board_model
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench for the gas alarm evaluator
// Assumes: one-second tick shortened to 10 clocks
// Notes: readings come through the sensor board model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import gas_alarm_pkg::*;
  logic clk_in, rst_in, ce_in, send, rd_valid, latch1, latch2, manual_reset;
  logic key_menu, key_add, key_sub, cal_screen, relay_fitted;
  logic [RD_W-1:0] send_val, reading;
  logic [9:0] cal_secs, cal_remaining_out;
  logic [3:0] flt, fault_code_out;
  logic amber_out, red_out, relay1_out, relay2_out, lockout_out, edit_dir_out, fault_out;
  logic [2:0] screen_out;
  logic [RD_W-1:0] edit_sp_out;
  logic f_adp, f_ifc, f_zero, f_cal;
  int n_mismatch = 0;
  int tests_run = 0;

  sensor_board_model board (.clk_in(clk_in), .rst_in(rst_in), .send_in(send),
    .value_in(send_val), .reading_out(reading), .valid_out(rd_valid));

  gas_alarm_evaluator #(.TICK_CYCLES(10)) DUT (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .reading_in(reading), .reading_valid_in(rd_valid),
    .key_menu_in(key_menu), .key_add_in(key_add), .key_sub_in(key_sub),
    .cal_screen_in(cal_screen), .cal_secs_in(cal_secs), .latch1_in(latch1),
    .latch2_in(latch2), .manual_reset_in(manual_reset), .relay_fitted_in(relay_fitted),
    .adapter_link_lost_in(flt[0]), .interface_link_lost_in(flt[1]),
    .zero_failed_in(flt[2]), .calibration_failed_in(flt[3]), .amber_out(amber_out),
    .red_out(red_out), .relay1_out(relay1_out), .relay2_out(relay2_out),
    .lockout_out(lockout_out), .screen_out(screen_out), .edit_sp_out(edit_sp_out),
    .edit_dir_out(edit_dir_out), .cal_remaining_out(cal_remaining_out),
    .adapter_link_lost_fault_out(f_adp), .interface_link_lost_fault_out(f_ifc),
    .zero_failed_fault_out(f_zero), .calibration_failed_fault_out(f_cal),
    .fault_code_out(fault_code_out), .fault_out(fault_out));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // k: 0 menu, 1 add, 2 sub, 3 cal screen, 4 manual reset
  task automatic press(input int k);
    @(posedge clk_in);
    case (k)
      0: key_menu <= 1'h1;
      1: key_add <= 1'h1;
      2: key_sub <= 1'h1;
      3: cal_screen <= 1'h1;
      default: manual_reset <= 1'h1;
    endcase
    @(posedge clk_in);
    {key_menu, key_add, key_sub, cal_screen, manual_reset} <= 5'h00;
    #1;
  endtask : press

  task automatic feed(input logic [RD_W-1:0] v);
    @(posedge clk_in);
    send <= 1'h1;
    send_val <= v;
    @(posedge clk_in);
    send <= 1'h0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : feed

  task automatic wait_clear(input bit cal, output int n);
    n = 0;
    while ((cal ? screen_out === 3'h6 : lockout_out === 1'h1) && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 2000) begin
      n_mismatch++;
      $display("[ERR] %0t wait bound used up", $time);
      finish_test();
    end
  endtask : wait_clear

  task automatic t_reset;
    check(screen_out, 16'h0, "screen after reset");
    check(edit_sp_out, 16'd200, "sp1 after reset");
    check(edit_dir_out, 16'h1, "dir1 after reset");
    check({amber_out, red_out, lockout_out, fault_out}, 16'h0, "outputs after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_rise;
    feed(10'd199);
    check(amber_out, 16'h0, "below sp1");
    feed(10'd200);
    check({amber_out, relay1_out}, 16'h3, "at sp1");
    feed(10'd180);
    check(amber_out, 16'h1, "inside margin");
    feed(10'd179);
    check({amber_out, relay1_out}, 16'h0, "auto release");
    @(posedge clk_in);
    relay_fitted <= 1'h0;
    feed(10'd400);
    check({amber_out, red_out, relay1_out, relay2_out}, 16'hC, "no relays");
    @(posedge clk_in);
    relay_fitted <= 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    check({relay1_out, relay2_out}, 16'h3, "relays follow");
    feed(10'd0);
    check({amber_out, red_out}, 16'h0, "both released");
    $display("test rise done");
  endtask : t_rise

  task automatic t_latch;
    @(posedge clk_in);
    latch1 <= 1'h1;
    latch2 <= 1'h1;
    feed(10'd450);
    feed(10'd0);
    check({amber_out, red_out}, 16'h3, "latched");
    press(4);
    repeat (2) @(posedge clk_in);
    #1;
    check({amber_out, red_out}, 16'h0, "manual reset");
    @(posedge clk_in);
    latch1 <= 1'h0;
    latch2 <= 1'h0;
    $display("test latch done");
  endtask : t_latch

  task automatic t_menu;
    int n;
    press(0);
    check(screen_out, 16'h1, "sp1 screen");
    check(lockout_out, 16'h1, "lockout in menu");
    repeat (250) press(2);
    check(edit_sp_out, 16'h1, "low clamp");
    repeat (800) press(1);
    check(edit_sp_out, 16'(FULL_SCALE * 70 / 100), "high clamp");
    // sp1 ends at 202, kept below sp2 at 400
    repeat (498) press(2);
    check(edit_sp_out, 16'd202, "edited sp1");
    press(0);
    check({screen_out, edit_dir_out}, 16'h5, "dir1 screen");
    press(2);
    check(edit_dir_out, 16'h0, "falling");
    press(1);
    check(edit_dir_out, 16'h1, "rising");
    press(2);
    press(0);
    check({screen_out, edit_sp_out}, 16'hD90, "sp2 screen");
    press(0);
    check({screen_out, edit_dir_out}, 16'h9, "dir2 screen");
    press(0);
    check({screen_out, lockout_out}, 16'h1, "back to normal");
    feed(10'd100);
    check(amber_out, 16'h0, "held off");
    wait_clear(1'b0, n);
    check(16'(n >= 570 && n <= 615), 16'h1, "lockout length");
    feed(10'd100);
    check(amber_out, 16'h1, "falling trip");
    feed(10'd222);
    check(amber_out, 16'h1, "falling margin");
    feed(10'd400);
    check({amber_out, red_out}, 16'h1, "falling release");
    feed(10'd360);
    check(red_out, 16'h1, "red margin");
    feed(10'd359);
    check(red_out, 16'h0, "red release");
    $display("test menu done");
  endtask : t_menu

  task automatic t_cal;
    int n;
    press(3);
    press(1);
    check(screen_out, 16'h5, "start screen");
    press(0);
    check({screen_out, cal_remaining_out}, 16'h180C, "countdown");
    press(0);
    press(2);
    check(screen_out, 16'h6, "no abort");
    wait_clear(1'b1, n);
    check(16'(n >= 105 && n <= 125), 16'h1, "countdown length");
    check(screen_out, 16'h0, "cal done");
    $display("test cal done");
  endtask : t_cal

  task automatic t_faults;
    logic [3:0] codes [4] = '{4'h1, 4'h4, 4'h5, 4'h6};
    // enable low must hold every register, fault flops included
    @(posedge clk_in);
    ce_in <= 1'h0;
    flt <= 4'h4;
    repeat (3) @(posedge clk_in);
    #1;
    check({fault_out, fault_code_out}, 16'h0, "enable low freezes");
    @(posedge clk_in);
    ce_in <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      flt <= 4'h1 << i;
      repeat (2) @(posedge clk_in);
      #1;
      check(fault_code_out, codes[i], "fault code");
      check({f_cal, f_zero, f_ifc, f_adp, fault_out}, {4'h1 << i, 1'h1}, "fault");
    end
    @(posedge clk_in);
    flt <= 4'hF;
    repeat (2) @(posedge clk_in);
    #1;
    check(fault_code_out, 16'h1, "priority");
    @(posedge clk_in);
    flt <= 4'h0;
    repeat (2) @(posedge clk_in);
    #1;
    check(fault_out, 16'h0, "fault clear");
    $display("test faults done");
  endtask : t_faults

  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    {rst_in, ce_in, relay_fitted} = 3'h7;
    {send, latch1, latch2, manual_reset, key_menu, key_add, key_sub, cal_screen} = 8'h00;
    send_val = '0;
    cal_secs = 10'h00C;
    flt = 4'h0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
    #1;
    t_reset();
    t_rise();
    t_latch();
    t_menu();
    t_cal();
    t_faults();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
